// *** kpi_top.sv ***
// Overview of operation
// - Status bits 7:4 read zero
// - Flag bit 3 ignores software writes
// - Acknowledge bit 2 clears, reads zero
// - Enable bit 1 gates interrupt request
// - Mode bit 0 selects edge or edge+level
// - Pin enable register, reset zero
// - Polarity register, one bit per pin
// - Falling edge: sampled high then low
// - Rising edge: sampled low then high
// - Edge sets flag, may request interrupt
// - Edge mode: acknowledge clears flag
// - Level mode: edge or level sets flag
// - Level mode: clear only when deasserted
// - Polarity picks pull-up or pull-down
// - Eight independently enabled pins
// - Runs in wait and background modes
// - Deep stop holds reset state
`timescale 1ns/1ns
`include "kpi_regs.svh"
module kpi_top (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire kpi_pkg::kpi_addr_t avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire kpi_pkg::kpi_pins_t key_input_pin,
    output kpi_pkg::kpi_pins_t      pull_down_sel,
    output logic                    irq_request
);
    import kpi_pkg::*;

    logic      irq_enable_q;
    kpi_mode_e detect_mode_q;
    logic      detect_flag_q;
    logic      deep_stop_q;
    kpi_pins_t key_pin_enable_q;
    kpi_pins_t key_polarity_select_q;
    kpi_pins_t pin_sync;
    kpi_pins_t pin_prev_q;
    kpi_pins_t asserted;
    kpi_pins_t prev_asserted;
    kpi_pins_t edge_hit;
    kpi_pins_t level_hit;
    logic      set_flag;
    logic      ack_write;
    logic      ack_clear;
    logic      any_asserted;
    kpi_bus_e  bus_q;
    logic      wr_fire;
    logic      rd_fire;

    function automatic kpi_pins_t kpi_norm(input kpi_pins_t raw, input kpi_pins_t pol);
        // Polarity one means high is asserted
        kpi_norm = ~(raw ^ pol);
    endfunction : kpi_norm

    kpi_sync u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (key_input_pin),
        .dout  (pin_sync)
    );

    // One wait cycle per access keeps reads registered
    assign wr_fire = (bus_q == KPI_RESP) && avs_write;
    assign rd_fire = (bus_q == KPI_RESP) && avs_read;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_q           <= KPI_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            case (bus_q)
                KPI_IDLE: begin
                    if ((avs_read || avs_write) && avs_waitrequest) begin
                        bus_q           <= KPI_RESP;
                        avs_waitrequest <= 1'b0;
                    end else begin
                        avs_waitrequest <= 1'b1;
                    end
                end
                KPI_RESP: begin
                    bus_q           <= KPI_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_q           <= KPI_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Read data prepared in the idle cycle, stable when waitrequest drops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_q == KPI_IDLE && avs_read) begin
            case (avs_address)
                `KPI_OFS_STATUS_CTRL: avs_readdata <= {28'h0000000, detect_flag_q, 1'b0,
                                                       irq_enable_q, detect_mode_q};
                `KPI_OFS_PIN_ENABLE:  avs_readdata <= {24'h000000, key_pin_enable_q};
                `KPI_OFS_POLARITY:    avs_readdata <= {24'h000000, key_polarity_select_q};
                `KPI_OFS_POWER_CTRL:  avs_readdata <= {31'h00000000, deep_stop_q};
                default:              avs_readdata <= `KPI_UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            deep_stop_q <= 1'b0;
        end else if (wr_fire && avs_address == `KPI_OFS_POWER_CTRL) begin
            deep_stop_q <= avs_writedata[`KPI_BIT_DEEP_STOP];
        end
    end

    // Deep stop forces the control, pin enable and polarity bits back to reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_q          <= 1'b0;
            detect_mode_q         <= KPI_EDGE_ONLY;
            key_pin_enable_q      <= `KPI_RST_PIN_ENABLE;
            key_polarity_select_q <= `KPI_RST_POLARITY;
        end else if (deep_stop_q) begin
            irq_enable_q          <= 1'b0;
            detect_mode_q         <= KPI_EDGE_ONLY;
            key_pin_enable_q      <= `KPI_RST_PIN_ENABLE;
            key_polarity_select_q <= `KPI_RST_POLARITY;
        end else if (wr_fire) begin
            case (avs_address)
                `KPI_OFS_STATUS_CTRL: begin
                    irq_enable_q  <= avs_writedata[`KPI_BIT_IRQ_EN];
                    detect_mode_q <= kpi_mode_e'(avs_writedata[`KPI_BIT_MODE]);
                end
                `KPI_OFS_PIN_ENABLE: key_pin_enable_q <= avs_writedata[7:0];
                `KPI_OFS_POLARITY:   key_polarity_select_q <= avs_writedata[7:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_q <= 8'h00;
        end else begin
            pin_prev_q <= pin_sync;
        end
    end

    always_comb begin
        asserted      = kpi_norm(pin_sync, key_polarity_select_q);
        prev_asserted = kpi_norm(pin_prev_q, key_polarity_select_q);
        // Deasserted one cycle, asserted the next
        edge_hit      = asserted & ~prev_asserted & key_pin_enable_q;
        level_hit     = asserted & key_pin_enable_q;
        any_asserted  = |level_hit;
        set_flag      = (|edge_hit) ||
                        (detect_mode_q == KPI_EDGE_LEVEL && any_asserted);
        ack_write     = wr_fire && avs_address == `KPI_OFS_STATUS_CTRL &&
                        avs_writedata[`KPI_BIT_ACK];
        ack_clear     = ack_write &&
                        (detect_mode_q == KPI_EDGE_ONLY || !any_asserted);
    end

    // Set wins over a same-cycle acknowledge; data bit 3 never stored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            detect_flag_q <= 1'b0;
        end else if (deep_stop_q) begin
            detect_flag_q <= 1'b0;
        end else if (set_flag) begin
            detect_flag_q <= 1'b1;
        end else if (ack_clear) begin
            detect_flag_q <= 1'b0;
        end
    end

    // Works through wait/background: no gating by CPU state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_request   <= 1'b0;
            pull_down_sel <= 8'h00;
        end else begin
            irq_request   <= detect_flag_q && irq_enable_q;
            pull_down_sel <= key_polarity_select_q;
        end
    end

    a_irq_follows: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> irq_request == ($past(detect_flag_q) && $past(irq_enable_q)))
        else $error("irq request mismatch");
    a_ctrl_upper_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && avs_address == `KPI_OFS_STATUS_CTRL)
        |-> avs_readdata[7:4] == 4'h0 && avs_readdata[2] == 1'b0)
        else $error("status upper or ack bit nonzero");
    a_flag_sets_edge: assert property (@(posedge clock) disable iff (!rst_n)
        (|edge_hit) && !deep_stop_q |=> detect_flag_q)
        else $error("edge did not set flag");
    a_flag_hold_level: assert property (@(posedge clock) disable iff (!rst_n)
        ack_write && detect_mode_q == KPI_EDGE_LEVEL && any_asserted && !deep_stop_q
        |=> detect_flag_q)
        else $error("flag cleared while pin asserted");
    a_ack_clears_edge: assert property (@(posedge clock) disable iff (!rst_n)
        ack_write && detect_mode_q == KPI_EDGE_ONLY && !(|edge_hit) |=> !detect_flag_q)
        else $error("ack did not clear flag");
    a_level_sets: assert property (@(posedge clock) disable iff (!rst_n)
        detect_mode_q == KPI_EDGE_LEVEL && any_asserted && !deep_stop_q |=> detect_flag_q)
        else $error("level did not set flag");
    a_flag_no_write: assert property (@(posedge clock) disable iff (!rst_n)
        !detect_flag_q && !set_flag |=> !detect_flag_q)
        else $error("flag set without detection");
    a_disabled_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        key_pin_enable_q == 8'h00 |-> !set_flag)
        else $error("disabled pins set flag");
    a_deep_stop_reset: assert property (@(posedge clock) disable iff (!rst_n)
        deep_stop_q |=> key_pin_enable_q == 8'h00 && !detect_flag_q && !irq_enable_q)
        else $error("deep stop left state");
    a_edge_two_samples: assert property (@(posedge clock) disable iff (!rst_n)
        edge_hit[0] |-> key_pin_enable_q[0] && (pin_sync[0] != pin_prev_q[0]))
        else $error("edge without transition");

    // Read-back at the answer edge; data was loaded one edge earlier
    a_ctrl_high_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && avs_address == `KPI_OFS_STATUS_CTRL)
        |-> avs_readdata[31:4] == 28'h0000000)
        else $error("status high bits nonzero");
    a_ack_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && avs_address == `KPI_OFS_STATUS_CTRL)
        |-> avs_readdata[`KPI_BIT_ACK] == 1'b0)
        else $error("ack bit read nonzero");
    a_flag_readback: assert property (@(posedge clock) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && avs_address == `KPI_OFS_STATUS_CTRL)
        |-> avs_readdata[`KPI_BIT_FLAG] == $past(detect_flag_q))
        else $error("flag read-back wrong");
    a_irq_en_readback: assert property (@(posedge clock) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && avs_address == `KPI_OFS_STATUS_CTRL)
        |-> avs_readdata[`KPI_BIT_IRQ_EN] == $past(irq_enable_q))
        else $error("irq enable read-back wrong");
    a_mode_readback: assert property (@(posedge clock) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && avs_address == `KPI_OFS_STATUS_CTRL)
        |-> avs_readdata[`KPI_BIT_MODE] == $past(detect_mode_q))
        else $error("mode read-back wrong");
    a_enable_readback: assert property (@(posedge clock) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && avs_address == `KPI_OFS_PIN_ENABLE)
        |-> avs_readdata == {24'h000000, $past(key_pin_enable_q)})
        else $error("pin enable read-back wrong");
    a_pol_readback: assert property (@(posedge clock) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && avs_address == `KPI_OFS_POLARITY)
        |-> avs_readdata == {24'h000000, $past(key_polarity_select_q)})
        else $error("polarity read-back wrong");

    // Register writes land at the answer edge unless deep stop holds them
    a_enable_write: assert property (@(posedge clock) disable iff (!rst_n)
        wr_fire && avs_address == `KPI_OFS_PIN_ENABLE && !deep_stop_q
        |=> key_pin_enable_q == $past(avs_writedata[7:0]))
        else $error("pin enable write lost");
    a_pol_write: assert property (@(posedge clock) disable iff (!rst_n)
        wr_fire && avs_address == `KPI_OFS_POLARITY && !deep_stop_q
        |=> key_polarity_select_q == $past(avs_writedata[7:0]))
        else $error("polarity write lost");
    a_irq_en_write: assert property (@(posedge clock) disable iff (!rst_n)
        wr_fire && avs_address == `KPI_OFS_STATUS_CTRL && !deep_stop_q
        |=> irq_enable_q == $past(avs_writedata[`KPI_BIT_IRQ_EN]))
        else $error("irq enable write lost");
    a_mode_write: assert property (@(posedge clock) disable iff (!rst_n)
        wr_fire && avs_address == `KPI_OFS_STATUS_CTRL && !deep_stop_q
        |=> detect_mode_q == $past(avs_writedata[`KPI_BIT_MODE]))
        else $error("mode write lost");
    a_flag_write_only: assert property (@(posedge clock) disable iff (!rst_n)
        wr_fire && avs_address == `KPI_OFS_STATUS_CTRL && !set_flag && !ack_clear
        && !deep_stop_q |=> detect_flag_q == $past(detect_flag_q))
        else $error("flag changed by write");

    // Detection and request paths
    a_fall_detect: assert property (@(posedge clock) disable iff (!rst_n)
        key_pin_enable_q[1] && !key_polarity_select_q[1] && pin_prev_q[1] && !pin_sync[1]
        |-> edge_hit[1])
        else $error("falling edge missed");
    a_rise_detect: assert property (@(posedge clock) disable iff (!rst_n)
        key_pin_enable_q[2] && key_polarity_select_q[2] && !pin_prev_q[2] && pin_sync[2]
        |-> edge_hit[2])
        else $error("rising edge missed");
    a_irq_on_flag: assert property (@(posedge clock) disable iff (!rst_n)
        detect_flag_q && irq_enable_q
        |=> irq_request)
        else $error("flag did not request interrupt");
    a_level_clear: assert property (@(posedge clock) disable iff (!rst_n)
        ack_write && detect_mode_q == KPI_EDGE_LEVEL && !any_asserted && !deep_stop_q
        |=> !detect_flag_q)
        else $error("released ack did not clear flag");
    a_irq_masked: assert property (@(posedge clock) disable iff (!rst_n)
        !irq_enable_q
        |=> !irq_request)
        else $error("masked interrupt requested");
    a_pull_follows: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1
        |=> pull_down_sel == $past(key_polarity_select_q))
        else $error("pull select lags polarity");
endmodule : kpi_top

// *** kpi_regs.svh ***
`ifndef KPI_REGS_SVH
`define KPI_REGS_SVH
`define KPI_OFS_STATUS_CTRL   4'h0
`define KPI_OFS_PIN_ENABLE    4'h4
`define KPI_OFS_POLARITY      4'h8
`define KPI_OFS_POWER_CTRL    4'hc
`define KPI_BIT_FLAG          3
`define KPI_BIT_ACK           2
`define KPI_BIT_IRQ_EN        1
`define KPI_BIT_MODE          0
`define KPI_BIT_DEEP_STOP     0
`define KPI_RST_CTRL          2'h0
`define KPI_RST_PIN_ENABLE    8'h00
`define KPI_RST_POLARITY      8'h00
`define KPI_UNMAPPED_DATA     32'h0000_0000
`define KPI_SYNC_STAGES       2
`endif

// *** kpi_pkg.sv ***
package kpi_pkg;
    typedef logic [7:0] kpi_pins_t;
    typedef logic [3:0] kpi_addr_t;
    typedef enum logic {KPI_EDGE_ONLY, KPI_EDGE_LEVEL} kpi_mode_e;
    typedef enum {KPI_IDLE, KPI_RESP} kpi_bus_e;
endpackage : kpi_pkg

// *** kpi_sync.sv ***
`timescale 1ns/1ns
`include "kpi_regs.svh"
module kpi_sync (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire kpi_pkg::kpi_pins_t din,
    output      kpi_pkg::kpi_pins_t dout
);
    import kpi_pkg::*;
    kpi_pins_t meta_q;

    // First stage read only by the second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 8'h00;
            dout   <= 8'h00;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : kpi_sync

// *** kpi_keys.sv ***
`timescale 1ns/1ns
module kpi_keys (
    input  wire kpi_pkg::kpi_pins_t pull_down_sel,
    input  wire kpi_pkg::kpi_pins_t press,
    output kpi_pkg::kpi_pins_t      pin
);
    import kpi_pkg::*;
    // Released keys rest at the resistor level, pressed keys short to the other rail
    assign pin = pull_down_sel ~^ press;
endmodule : kpi_keys

// *** tb_keypad_pin_interrupt.sv ***
`timescale 1ns/1ns
`include "kpi_regs.svh"
module tb_keypad_pin_interrupt;
    import kpi_pkg::*;
    localparam kpi_addr_t SC = `KPI_OFS_STATUS_CTRL;
    localparam kpi_addr_t PE = `KPI_OFS_PIN_ENABLE;
    localparam kpi_addr_t PS = `KPI_OFS_POLARITY;
    logic        clock           = 1'b0;
    logic        rst_n           = 1'b0;
    kpi_addr_t   avs_address     = 4'h0;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    kpi_pins_t   key_input_pin;
    kpi_pins_t   pull_down_sel;
    kpi_pins_t   press           = 8'h00;
    logic        irq_request;
    int          n_mismatch      = 0;
    int          n_checks        = 0;
    int          cycles          = 0;

    always #20 clock = ~clock;

    kpi_top dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .key_input_pin(key_input_pin), .pull_down_sel(pull_down_sel),
        .irq_request(irq_request));
    kpi_keys keys (.pull_down_sel(pull_down_sel), .press(press), .pin(key_input_pin));

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // Hang guard, far above the under a thousand cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(string w, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic wr(kpi_addr_t a, logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd_chk(kpi_addr_t a, logic [31:0] e, string w);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        chk(w, e, avs_readdata);
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : rd_chk

    // Safe bring-up order: mask, polarity, pins, acknowledge, unmask
    task automatic arm(kpi_pins_t pol, kpi_pins_t pe, logic m);
        wr(SC, {31'h0, m});
        wr(PS, {24'h0, pol});
        wr(PE, {24'h0, pe});
        wr(SC, {29'h0, 3'h4} | m);
        wr(SC, {29'h0, 3'h2} | m);
    endtask : arm

    task automatic settle();
        repeat (6) @(posedge clock);
    endtask : settle

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd_chk(SC, 32'h0, "ctrl reset");
        rd_chk(PE, 32'h0, "enable reset");
        rd_chk(PS, 32'h0, "polarity reset");
        rd_chk(4'h2, 32'h0, "unmapped read");
        wr(4'h2, 32'hff);
        wr(PS, 32'ha5);
        @(posedge clock);
        chk("pull select", 32'ha5, {24'h0, pull_down_sel});
        wr(SC, 32'hff);
        rd_chk(SC, 32'h3, "ctrl bits");
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            arm(i[3] ? 8'hff : 8'h00, 8'h01 << i[2:0], 1'b0);
            press <= 8'h01 << ((i + 1) % 8);
            settle();
            rd_chk(SC, 32'h2, "disabled pin");
            press <= 8'h01 << i[2:0];
            settle();
            chk("edge irq", 32'h1, {31'h0, irq_request});
            rd_chk(SC, 32'ha, "edge flag");
            press <= 8'h00;
            settle();
            wr(SC, 32'h6);
            rd_chk(SC, 32'h2, "edge ack");
            chk("irq cleared", 32'h0, {31'h0, irq_request});
        end
        $display("test edges done");
        arm(8'h00, 8'h00, 1'b1);
        press <= 8'h10;
        settle();
        wr(PE, 32'h10);
        settle();
        rd_chk(SC, 32'hb, "level flag");
        wr(SC, 32'h7);
        rd_chk(SC, 32'hb, "held ack");
        wr(SC, 32'h1);
        settle();
        chk("masked irq", 32'h0, {31'h0, irq_request});
        wr(SC, 32'h3);
        settle();
        chk("unmasked irq", 32'h1, {31'h0, irq_request});
        press <= 8'h00;
        settle();
        wr(SC, 32'h7);
        rd_chk(SC, 32'h3, "released ack");
        $display("test levels done");
        press <= 8'h10;
        wr(PS, 32'h5a);
        wr(`KPI_OFS_POWER_CTRL, 32'h1);
        wr(`KPI_OFS_POWER_CTRL, 32'h0);
        rd_chk(PE, 32'h0, "wake enable");
        rd_chk(PS, 32'h0, "wake polarity");
        rd_chk(SC, 32'h0, "wake ctrl");
        $display("test deep stop done");
        summarize();
    end
endmodule : tb_keypad_pin_interrupt
